// *** hw/fswp_top.sv ***
/*
  Status and write-protect core of a serial flash: latch, status and write
  commands, program and erase gating, status shift-out.
  Assumes an SPI host in mode 0 or 3 far slower than the system clock;
  the array sits outside and follows op_start_out.
*/
// How it works
// [R1] Protection, quad and lock bits change only through a status-write command.
// [R2] Protection, quad and lock bits come up cleared.
// [R3] Bit 0 reads one while a write cycle runs, else zero.
// [R4] Latch at bit 1; a clear latch blocks all write commands.
// [R5] Set-latch command sets the latch; host sends it before each write.
// [R6] Clear-latch command clears latch; latch also clears when a write cycle ends.
// [R7] Protection code at bits 2..5 refuses program or erase in protected blocks.
// [R8] Codes 1..5 protect upper ranges ending at block 31; code 0 none.
// [R9] Codes A..E protect lower ranges from block 0; 6..9 and F all.
// [R10] Whole-array erase runs only with protection code zero.
// [R11] Lock at bit 7 with write-protect pin low and quad enable clear ignores status writes.
// [R12] Status writes accepted with lock clear, or lock set and pin high.
// [R13] Quad enable at bit 6 turns the two control pins into data lanes.
// [R14] Host must not set quad enable when those pins are tied to rails.
// [R15] Write commands run only on whole bytes; partial frames are dropped.
// [R16] Status-read returns all eight status bits.
// [R17] Command byte arrives first, most significant bit first, on rising edges.
// [R18] Block n spans addresses n*64K to n*64K+0xFFFF.
// [R19] Status-write loads bits 7..2 only; busy and latch stay internal.
// [R20] While busy, status reads answer and write commands are ignored.
// [R21] A write refused by protection leaves the latch set.
module fswp_top
    import fswp_pkg::*;
#(
    parameter logic [15:0] OP_CYCLES = OP_BUSY_CYCLES
)
(
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        sck_in,
    input  wire logic        cs_n_in,
    input  wire logic        si_in,
    input  wire logic        wp_n_in,
    output logic             so_out,
    output logic             so_oe_n_out,
    output logic [7:0]       status_out,
    output logic             quad_lane_enable_out,
    output logic             op_start_out,
    output fswp_op_t         op_kind_out,
    output logic [ADDR_W-1:0] op_addr_out
);

    fswp_link_if link();

    logic              wp_meta_reg;
    logic              wp_sync_reg;
    logic [2:0]        byte_num_reg;
    logic [7:0]        opcode_reg;
    logic [7:0]        data_byte_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              busy_flag_reg;
    logic [15:0]       busy_cnt_reg;
    logic              write_latch_flag_reg;
    logic [3:0]        protect_level_reg;
    logic              quad_lane_enable_reg;
    logic              status_lock_bit_reg;
    logic [7:0]        out_shift_reg;
    logic              so_reg;
    logic              so_oe_n_reg;
    logic [7:0]        status_out_reg;
    logic              quad_out_reg;
    logic              op_start_reg;
    fswp_op_t          op_kind_reg;
    logic [ADDR_W-1:0] op_addr_reg;

    logic [7:0]        status_now;
    logic              prot_hit;
    logic              any_prot;
    logic              have_opcode;
    logic              whole_bytes;
    logic              write_gate;
    logic              status_unlocked;
    logic              go_prog;
    logic              go_sect;
    logic              go_block;
    logic              go_whole;
    logic              go_stat;
    logic              start_any;
    logic              set_latch;
    logic              clear_latch;
    logic              op_done;
    fswp_op_t          kind_next;
    logic [BLOCK_W-1:0] block_sel;

    fswp_spi_rx u_rx (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .sck_in   (sck_in),
        .cs_n_in  (cs_n_in),
        .si_in    (si_in),
        .link     (link.rx)
    );

    // [R18] Block from address bits 20..16
    assign block_sel = addr_reg[BLOCK_ADDR_LSB+BLOCK_W-1:BLOCK_ADDR_LSB];

    // [R7] Protected-area lookup
    fswp_prot_dec u_dec (
        .code_in      (protect_level_reg),
        .block_in     (block_sel),
        .prot_hit_out (prot_hit),
        .any_prot_out (any_prot)
    );

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_meta_reg <= 1'b0;
            wp_sync_reg <= 1'b0;
        end else begin
            wp_meta_reg <= wp_n_in;
            wp_sync_reg <= wp_meta_reg;
        end
    end

    // [R17] Opcode is the first byte
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_num_reg  <= 3'h0;
            opcode_reg    <= 8'h00;
            data_byte_reg <= 8'h00;
            addr_reg      <= '0;
        end else if (link.frame_start) begin
            byte_num_reg  <= 3'h0;
            opcode_reg    <= 8'h00;
            data_byte_reg <= 8'h00;
            addr_reg      <= '0;
        end else if (link.byte_done) begin
            if (byte_num_reg != 3'h7) begin
                byte_num_reg <= byte_num_reg + 3'h1;
            end
            case (byte_num_reg)
                3'h0: begin
                    opcode_reg <= link.byte_val;
                end
                3'h1: begin
                    data_byte_reg   <= link.byte_val;
                    addr_reg[23:16] <= link.byte_val;
                end
                3'h2: begin
                    addr_reg[15:8] <= link.byte_val;
                end
                3'h3: begin
                    addr_reg[7:0] <= link.byte_val;
                end
                default: begin
                end
            endcase
        end
    end

    assign status_now = {status_lock_bit_reg, quad_lane_enable_reg, protect_level_reg,
                         write_latch_flag_reg, busy_flag_reg};

    always_comb begin
        have_opcode = (byte_num_reg != 3'h0);
        // [R15] Whole-byte check at frame end
        whole_bytes = (link.bit_cnt[2:0] == 3'h0);
        // [R4] Latch gates writes
        // [R20] Busy blocks writes
        write_gate  = link.frame_end && have_opcode && whole_bytes && !busy_flag_reg &&
                      write_latch_flag_reg;
        // [R11] Lock with pin low
        // [R12] Lock open or pin high
        // [R13] Pin is a data lane in quad mode, so it cannot lock
        status_unlocked = !status_lock_bit_reg || wp_sync_reg || quad_lane_enable_reg;
        // [R7] Refuse protected blocks
        go_prog  = write_gate && ((opcode_reg == OPC_PAGE_PROG) || (opcode_reg == OPC_QUAD_PROG)) &&
                   (link.bit_cnt >= BITS_PROG_MIN) && !prot_hit;
        go_sect  = write_gate && ((opcode_reg == OPC_SECT_ERASE_A) || (opcode_reg == OPC_SECT_ERASE_B)) &&
                   (link.bit_cnt == BITS_ERASE) && !prot_hit;
        go_block = write_gate && (opcode_reg == OPC_BLOCK_ERASE) &&
                   (link.bit_cnt == BITS_ERASE) && !prot_hit;
        // [R10] Whole erase needs code zero
        go_whole = write_gate && ((opcode_reg == OPC_WHOLE_ERASE_A) || (opcode_reg == OPC_WHOLE_ERASE_B)) &&
                   (link.bit_cnt == BITS_ONE_BYTE) && !any_prot;
        go_stat  = write_gate && (opcode_reg == OPC_STAT_WRITE) &&
                   (link.bit_cnt == BITS_STAT_WRITE) && status_unlocked;
        start_any = go_prog || go_sect || go_block || go_whole || go_stat;
        // [R5] Set-latch decode
        set_latch   = link.frame_end && have_opcode && (opcode_reg == OPC_SET_LATCH) &&
                      (link.bit_cnt == BITS_ONE_BYTE);
        // [R6] Clear-latch decode
        clear_latch = link.frame_end && have_opcode && (opcode_reg == OPC_CLEAR_LATCH) &&
                      (link.bit_cnt == BITS_ONE_BYTE);
        op_done     = busy_flag_reg && (busy_cnt_reg == 16'h0001);
        if (go_prog) begin
            kind_next = OP_PROG;
        end else if (go_sect) begin
            kind_next = OP_SECT;
        end else if (go_block) begin
            kind_next = OP_BLOCK;
        end else if (go_whole) begin
            kind_next = OP_WHOLE;
        end else if (go_stat) begin
            kind_next = OP_STAT;
        end else begin
            kind_next = OP_NONE;
        end
    end

    // [R3] Busy for the length of a write cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_flag_reg <= 1'b0;
            busy_cnt_reg  <= 16'h0000;
        end else if (start_any) begin
            busy_flag_reg <= 1'b1;
            busy_cnt_reg  <= OP_CYCLES;
        end else if (busy_flag_reg) begin
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
            if (op_done) begin
                busy_flag_reg <= 1'b0;
            end
        end
    end

    // [R5] Set wins over an ending cycle
    // [R6] Clear on command or cycle end
    // [R21] Refused writes keep the latch
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_latch_flag_reg <= 1'b0;
        end else if (set_latch) begin
            write_latch_flag_reg <= 1'b1;
        end else if (clear_latch || op_done) begin
            write_latch_flag_reg <= 1'b0;
        end
    end

    // [R1] Only a status write changes these
    // [R2] Cleared at power-up
    // [R19] Bits 7..2 from the data byte
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            protect_level_reg    <= PROT_RESET;
            quad_lane_enable_reg <= STATUS_RESET[QUAD_BIT];
            status_lock_bit_reg  <= STATUS_RESET[LOCK_BIT];
        end else if (go_stat) begin
            protect_level_reg    <= data_byte_reg[PROT_MSB:PROT_LSB];
            quad_lane_enable_reg <= data_byte_reg[QUAD_BIT];
            status_lock_bit_reg  <= data_byte_reg[LOCK_BIT];
        end
    end

    // [R16] Status shifts out on falling edges
    // [R20] Reads still answer while busy
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_shift_reg <= 8'h00;
            so_reg        <= 1'b0;
            so_oe_n_reg   <= 1'b1;
        end else begin
            so_oe_n_reg <= !(link.frame_active && have_opcode && (opcode_reg == OPC_STAT_READ));
            if (link.sck_fall && have_opcode && (opcode_reg == OPC_STAT_READ)) begin
                // Reload each byte so a polling host sees the busy flag drop
                if (link.bit_cnt[2:0] == 3'h0) begin
                    so_reg        <= status_now[7];
                    out_shift_reg <= {status_now[6:0], 1'b0};
                end else begin
                    so_reg        <= out_shift_reg[7];
                    out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_out_reg <= STATUS_RESET;
            quad_out_reg   <= STATUS_RESET[QUAD_BIT];
            op_start_reg   <= 1'b0;
            op_kind_reg    <= OP_NONE;
            op_addr_reg    <= '0;
        end else begin
            status_out_reg <= status_now;
            // [R13] Lane function select
            quad_out_reg   <= quad_lane_enable_reg;
            op_start_reg   <= start_any;
            if (start_any) begin
                op_kind_reg <= kind_next;
                op_addr_reg <= addr_reg;
            end
        end
    end

    assign so_out               = so_reg;
    assign so_oe_n_out          = so_oe_n_reg;
    assign status_out           = status_out_reg;
    assign quad_lane_enable_out = quad_out_reg;
    assign op_start_out         = op_start_reg;
    assign op_kind_out          = op_kind_reg;
    assign op_addr_out          = op_addr_reg;

endmodule : fswp_top

// *** inc/fswp_pkg.sv ***
/*
  Constants, opcodes and types of the status and protect logic.
  Assumes one system clock; serial pins are sampled into it.
*/
package fswp_pkg;

    // Command codes
    localparam logic [7:0]  OPC_SET_LATCH     = 8'h06;
    localparam logic [7:0]  OPC_CLEAR_LATCH   = 8'h04;
    localparam logic [7:0]  OPC_STAT_READ     = 8'h05;
    localparam logic [7:0]  OPC_STAT_WRITE    = 8'h01;
    localparam logic [7:0]  OPC_PAGE_PROG     = 8'h02;
    localparam logic [7:0]  OPC_QUAD_PROG     = 8'h32;
    localparam logic [7:0]  OPC_SECT_ERASE_A  = 8'hD7;
    localparam logic [7:0]  OPC_SECT_ERASE_B  = 8'h20;
    localparam logic [7:0]  OPC_BLOCK_ERASE   = 8'hD8;
    localparam logic [7:0]  OPC_WHOLE_ERASE_A = 8'hC7;
    localparam logic [7:0]  OPC_WHOLE_ERASE_B = 8'h60;

    // Status byte layout
    localparam int          BUSY_BIT          = 0;
    localparam int          LATCH_BIT         = 1;
    localparam int          PROT_LSB          = 2;
    localparam int          PROT_MSB          = 5;
    localparam int          QUAD_BIT          = 6;
    localparam int          LOCK_BIT          = 7;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;
    localparam logic [3:0]  PROT_RESET        = 4'h0;

    // Frame lengths in clock pulses
    localparam int          CNT_W             = 12;
    localparam logic [11:0] BITS_ONE_BYTE     = 12'h008;
    localparam logic [11:0] BITS_STAT_WRITE   = 12'h010;
    localparam logic [11:0] BITS_ERASE        = 12'h020;
    localparam logic [11:0] BITS_PROG_MIN     = 12'h028;

    // Array geometry: 32 blocks of 64 KB
    localparam int          ADDR_W            = 24;
    localparam int          BLOCK_COUNT       = 32;
    localparam int          BLOCK_W           = 5;
    localparam int          BLOCK_ADDR_LSB    = 16;

    // Upper range starts, lower range ends
    localparam logic [4:0]  UP_START_1        = 5'h1F;
    localparam logic [4:0]  UP_START_2        = 5'h1E;
    localparam logic [4:0]  UP_START_3        = 5'h1C;
    localparam logic [4:0]  UP_START_4        = 5'h18;
    localparam logic [4:0]  UP_START_5        = 5'h10;
    localparam logic [4:0]  LO_END_A          = 5'h0F;
    localparam logic [4:0]  LO_END_B          = 5'h17;
    localparam logic [4:0]  LO_END_C          = 5'h1B;
    localparam logic [4:0]  LO_END_D          = 5'h1D;
    localparam logic [4:0]  LO_END_E          = 5'h1E;

    // Write cycle length in clocks
    localparam logic [15:0] OP_BUSY_CYCLES    = 16'h0040;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_PROG,
        OP_SECT,
        OP_BLOCK,
        OP_WHOLE,
        OP_STAT
    } fswp_op_t;

endpackage : fswp_pkg

// *** inc/fswp_link_if.sv ***
/*
  Carrier from the serial front end to the core.
  Assumes one shared clock.
*/
interface fswp_link_if;
    logic        frame_active;
    logic        frame_start;
    logic        frame_end;
    logic        sck_fall;
    logic        byte_done;
    logic [7:0]  byte_val;
    logic [11:0] bit_cnt;

    modport rx   (output frame_active, frame_start, frame_end, sck_fall, byte_done, byte_val, bit_cnt);
    modport core (input  frame_active, frame_start, frame_end, sck_fall, byte_done, byte_val, bit_cnt);
endinterface : fswp_link_if

// *** hw/fswp_spi_rx.sv ***
/*
  Serial front end: synchronises pins, finds clock edges, shifts bytes in MSB first.
  Assumes a serial clock far below the system clock.
*/
module fswp_spi_rx
    import fswp_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic sck_in,
    input  wire logic cs_n_in,
    input  wire logic si_in,
    fswp_link_if.rx   link
);

    logic             sck_meta_reg, sck_sync_reg, sck_prev_reg;
    logic             cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic             si_meta_reg, si_sync_reg;
    logic [7:0]       shift_reg;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic             byte_done_reg;
    logic             sck_rise;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_meta_reg <= 1'b0;
            sck_sync_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            cs_prev_reg  <= 1'b1;
            si_meta_reg  <= 1'b0;
            si_sync_reg  <= 1'b0;
        end else begin
            sck_meta_reg <= sck_in;
            sck_sync_reg <= sck_meta_reg;
            sck_prev_reg <= sck_sync_reg;
            cs_meta_reg  <= cs_n_in;
            cs_sync_reg  <= cs_meta_reg;
            cs_prev_reg  <= cs_sync_reg;
            si_meta_reg  <= si_in;
            si_sync_reg  <= si_meta_reg;
        end
    end

    assign sck_rise = sck_sync_reg && !sck_prev_reg && !cs_sync_reg;

    // [R17] Sample on rising edges
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= '0;
            byte_done_reg <= 1'b0;
        end else if (!cs_sync_reg && cs_prev_reg) begin
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= '0;
            byte_done_reg <= 1'b0;
        end else begin
            byte_done_reg <= sck_rise && (bit_cnt_reg[2:0] == 3'h7);
            if (sck_rise) begin
                shift_reg <= {shift_reg[6:0], si_sync_reg};
                // Saturates: a long burst never wraps to a whole count
                if (bit_cnt_reg != '1) begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                end
            end
        end
    end

    assign link.frame_active = !cs_sync_reg;
    assign link.frame_start  = !cs_sync_reg && cs_prev_reg;
    assign link.frame_end    = cs_sync_reg && !cs_prev_reg;
    assign link.sck_fall     = !sck_sync_reg && sck_prev_reg && !cs_sync_reg;
    assign link.byte_done    = byte_done_reg;
    assign link.byte_val     = shift_reg;
    assign link.bit_cnt      = bit_cnt_reg;

endmodule : fswp_spi_rx

// *** hw/fswp_prot_dec.sv ***
/*
  Protected-area decode: one mask bit per 64 KB block from the protection code.
  Assumes the caller registers the result before it reaches a pin.
*/
module fswp_prot_dec
    import fswp_pkg::*;
(
    input  wire logic [3:0]         code_in,
    input  wire logic [BLOCK_W-1:0] block_in,
    output logic                    prot_hit_out,
    output logic                    any_prot_out
);

    logic [BLOCK_COUNT-1:0] mask;

    function automatic logic blk_prot(input logic [3:0] code, input logic [BLOCK_W-1:0] blk);
        case (code)
            4'h0:    blk_prot = 1'b0;
            4'h1:    blk_prot = (blk >= UP_START_1);
            4'h2:    blk_prot = (blk >= UP_START_2);
            4'h3:    blk_prot = (blk >= UP_START_3);
            4'h4:    blk_prot = (blk >= UP_START_4);
            4'h5:    blk_prot = (blk >= UP_START_5);
            4'hA:    blk_prot = (blk <= LO_END_A);
            4'hB:    blk_prot = (blk <= LO_END_B);
            4'hC:    blk_prot = (blk <= LO_END_C);
            4'hD:    blk_prot = (blk <= LO_END_D);
            4'hE:    blk_prot = (blk <= LO_END_E);
            default: blk_prot = 1'b1;
        endcase
    endfunction : blk_prot

    // [R8] Upper ranges
    // [R9] Lower ranges and all
    for (genvar b = 0; b < BLOCK_COUNT; b++) begin : g_blk
        assign mask[b] = blk_prot(code_in, BLOCK_W'(b));
    end

    assign prot_hit_out = mask[block_in];
    assign any_prot_out = |code_in;

endmodule : fswp_prot_dec

// *** tb/fswp_host_model.sv ***
/* Mode 0 SPI host model for the status block.
   Assumes a 100 ns clock; a bit spans eight clocks. */
module fswp_host_model (
    input  wire logic clock_in,
    input  wire logic so_in,
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      si_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rd_reg = 8'h00;
    initial begin
        sck_out  = 1'b0;
        cs_n_out = 1'b1;
        si_out   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask : tick
    task automatic frame(input logic [47:0] bits, input int n);
        cs_n_out <= 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            si_out  <= bits[47-i];
            tick(4);
            sck_out <= 1'b1;
            tick(4);
            rd_reg  <= {rd_reg[6:0], so_in};
            sck_out <= 1'b0;
        end
        tick(4);
        cs_n_out <= 1'b1;
        si_out   <= ~si_out;
        tick(8);
    endtask : frame
endmodule : fswp_host_model

// *** tb/fswp_monitor.sv ***
/* Port checker for the status block.
   Assumes the package status layout. */
module fswp_monitor
    import fswp_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       rst_n_in,
    input wire logic       cs_n_in,
    input wire logic       wp_n_in,
    input wire logic       so_oe_n_out,
    input wire logic [7:0] status_out,
    input wire logic       op_start_out,
    input wire fswp_op_t   op_kind_out
);
    wire stat_go = op_start_out && op_kind_out == OP_STAT;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    a_busy_runs: assert property (op_start_out |=> status_out[BUSY_BIT] [*8])
        else $error("busy too short");
    a_idle_start: assert property (status_out[BUSY_BIT] |-> !op_start_out)
        else $error("start while busy");
    a_start_latch: assert property (op_start_out |-> status_out[LATCH_BIT])
        else $error("start without latch");
    a_latch_auto: assert property ($fell(status_out[BUSY_BIT]) |-> !status_out[LATCH_BIT])
        else $error("latch kept after cycle");
    a_whole_free: assert property (op_start_out && op_kind_out == OP_WHOLE |-> status_out[5:2] == 4'h0)
        else $error("whole erase while protected");
    a_all_prot: assert property (op_start_out && !stat_go |-> !(status_out[5:2] inside {[4'h6:4'h9], 4'hF}))
        else $error("write into fully protected array");
    a_nv_hold: assert property ($changed(status_out[7:2]) |-> $past(stat_go))
        else $error("status bits changed without status write");
    a_lock_wp: assert property (stat_go |-> !status_out[LOCK_BIT] || status_out[QUAD_BIT] || wp_n_in)
        else $error("locked status written");
    a_oe_off: assert property (cs_n_in [*8] |-> so_oe_n_out)
        else $error("output driven while deselected");
    a_start_framed: assert property (op_start_out |-> cs_n_in && $past(cs_n_in, 3))
        else $error("start inside frame");
endmodule : fswp_monitor

bind fswp_top fswp_monitor u_monitor (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .cs_n_in      (cs_n_in),
    .wp_n_in      (wp_n_in),
    .so_oe_n_out  (so_oe_n_out),
    .status_out   (status_out),
    .op_start_out (op_start_out),
    .op_kind_out  (op_kind_out)
);

// *** tb/testbench.sv ***
/* Self-checking bench for the status and protect top.
   Assumes the host model drives the pins; write cycle of 384 clocks, six times the default. */
module testbench
    import fswp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] OPC = 16'h0180;
    logic        clk, rst_n, wp_n, sck, cs_n, si, so, so_w, so_oe_n, quad, start;
    logic [7:0]  status;
    logic [23:0] addr;
    fswp_op_t    kind;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          starts = 0;
    assign so_w = so_oe_n ? ~so : so;
    fswp_top #(.OP_CYCLES(OPC)) DUT (
        .clock_in             (clk),
        .rst_n_in             (rst_n),
        .sck_in               (sck),
        .cs_n_in              (cs_n),
        .si_in                (si),
        .wp_n_in              (wp_n),
        .so_out               (so),
        .so_oe_n_out          (so_oe_n),
        .status_out           (status),
        .quad_lane_enable_out (quad),
        .op_start_out         (start),
        .op_kind_out          (kind),
        .op_addr_out          (addr)
    );
    fswp_host_model HOST (
        .clock_in (clk),
        .so_in    (so_w),
        .sck_out  (sck),
        .cs_n_out (cs_n),
        .si_out   (si)
    );
    function automatic logic prot(input logic [3:0] c, input int b);
        case (c)
            4'h0: prot = 1'b0;
            4'h1: prot = b >= 31;
            4'h2: prot = b >= 30;
            4'h3: prot = b >= 28;
            4'h4: prot = b >= 24;
            4'h5: prot = b >= 16;
            4'hA: prot = b <= 15;
            4'hB: prot = b <= 23;
            4'hC: prot = b <= 27;
            4'hD: prot = b <= 29;
            4'hE: prot = b <= 30;
            default: prot = 1'b1;
        endcase
    endfunction : prot
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic idle;
        int k = 0;
        while (status[BUSY_BIT] !== 1'b0 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        if (k == 1000) fail_count++;
        repeat (2) @(posedge clk);
    endtask : idle
    task automatic set_latch_cmd;
        HOST.frame({OPC_SET_LATCH, 40'h0}, 8);
    endtask : set_latch_cmd
    task automatic wsr(input logic [7:0] d);
        set_latch_cmd;
        HOST.frame({OPC_STAT_WRITE, d, 32'h0}, 16);
        idle;
    endtask : wsr
    task automatic t_latch;
        chk("reset", 8'h00, status);
        HOST.frame({OPC_SET_LATCH, 40'h0}, 7);
        chk("short", 8'h00, status);
        set_latch_cmd;
        chk("set", 8'h02, status);
        HOST.frame({OPC_STAT_WRITE, 8'h3C, 32'h0}, 15);
        chk("partial", 8'h02, status);
        HOST.frame({OPC_STAT_READ, 40'h0}, 16);
        chk("read", 8'h02, HOST.rd_reg);
        HOST.frame({OPC_CLEAR_LATCH, 40'h0}, 8);
        chk("clear", 8'h00, status);
        HOST.frame({OPC_STAT_WRITE, 8'h3C, 32'h0}, 16);
        chk("no latch", 8'h00, status);
        $display("latch test done");
    endtask : t_latch
    task automatic t_write;
        set_latch_cmd;
        HOST.frame({OPC_STAT_WRITE, 8'h1F, 32'h0}, 16);
        chk("busy", 8'h1F, status);
        idle;
        chk("written", 8'h1C, status);
        set_latch_cmd;
        HOST.frame({OPC_STAT_WRITE, 8'h04, 32'h0}, 16);
        HOST.frame({OPC_STAT_WRITE, 8'h08, 32'h0}, 16);
        HOST.frame({OPC_STAT_READ, 40'h0}, 16);
        chk("busy read", 8'h07, HOST.rd_reg);
        idle;
        chk("ignored", 8'h04, status);
        $display("write test done");
    endtask : t_write
    task automatic t_lock;
        wsr(8'hC0); // bench lanes are not tied to rails
        chk("quad", 8'h01, quad);
        wp_n <= 1'b0;
        wsr(8'h80);
        chk("quad wr", 8'h80, status);
        wsr(8'h3C);
        chk("locked", 8'h82, status);
        wp_n <= 1'b1;
        wsr(8'h00);
        chk("unlocked", 8'h00, status);
        $display("lock test done");
    endtask : t_lock
    task automatic t_prot;
        int   blks[5] = '{0, 15, 16, 30, 31};
        logic e;
        int   n;
        for (int c = 0; c < 16; c++) begin
            wsr({2'b00, 4'(c), 2'b00});
            foreach (blks[j]) begin
                e = !prot(4'(c), blks[j]);
                n = starts;
                set_latch_cmd;
                HOST.frame({j == 4 ? OPC_PAGE_PROG : j[0] ? OPC_SECT_ERASE_B : OPC_BLOCK_ERASE,
                            3'h0, 5'(blks[j]), 32'h0}, j == 4 ? 40 : 32);
                chk("block", 8'(e), 8'(starts - n));
                if (e) chk("addr", 8'(blks[j]), addr[23:16]);
                idle;
                chk("latch", 8'(!e), 8'(status[LATCH_BIT]));
            end
            n = starts;
            set_latch_cmd;
            HOST.frame({c[0] ? OPC_WHOLE_ERASE_A : OPC_WHOLE_ERASE_B, 40'h0}, 8);
            chk("whole", 8'(c == 0), 8'(starts - n));
            idle;
        end
        $display("protect test done");
    endtask : t_prot
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    initial begin
        #9_000_000;
        fail_count++;
        print_verdict;
    end
    initial begin
        rst_n = 1'b0;
        wp_n  = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_latch;
        t_write;
        wsr(8'h00);
        t_lock;
        t_prot;
        print_verdict;
    end
endmodule : testbench
